/* File: rtl/omc_defines.svh */
/*
 * Bit positions, reset values and timing counts of the operating mode and
 * channel control block.
 * Assumes inclusion by bare name from the design files only.
 */
`ifndef OMC_DEFINES_SVH
`define OMC_DEFINES_SVH

// ****************************************************************
// Mode request bit positions and request width
// ****************************************************************
`define OMC_REQ_AUTO      0
`define OMC_REQ_MDATA     1
`define OMC_REQ_JOG       2
`define OMC_REQ_W         3

// ****************************************************************
// Reset values
// ****************************************************************
`define OMC_MODE_RST      2'h0
`define OMC_CHAN_RST      2'h0

// ****************************************************************
// Timing counts and counter width
// ****************************************************************
`define OMC_RSEQ_CYC      4'h4
`define OMC_CNT_W         4

`endif

/* File: rtl/omc_pkg.sv */
/*
 * Types of the operating mode and channel control block.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package omc_pkg;

	// ****************************************************************
	// Operating modes and channel states
	// ****************************************************************
	typedef enum logic [1:0] {
		OMC_AUTO  = 2'h0,
		OMC_MDATA = 2'h1,
		OMC_JOG   = 2'h2
	} omc_mode_t;

	typedef enum logic [1:0] {
		OMC_CH_RESET = 2'h0,
		OMC_CH_ACT   = 2'h1,
		OMC_CH_INT   = 2'h2,
		OMC_CH_RSEQ  = 2'h3
	} omc_chan_t;

endpackage

/* File: rtl/omc_sync3.sv */
/*
 * Three-stage input synchroniser with agreement filter.
 * Assumes inputs asynchronous to clk_sys; output changes when the second
 * and third stage agree.
 */
`timescale 1ns/1ps

module omc_sync3 #(
	parameter int W = 1
) (
	input  wire logic         clk_sys,
	input  wire logic         resetn,
	input  wire logic [W-1:0] din,
	output logic      [W-1:0] dout
);

	logic [W-1:0] s1_ff;
	logic [W-1:0] s2_ff;
	logic [W-1:0] s3_ff;

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			s1_ff <= '0;
			s2_ff <= '0;
			s3_ff <= '0;
			dout  <= '0;
		end else begin
			s1_ff <= din;
			s2_ff <= s1_ff;
			s3_ff <= s2_ff;
			dout  <= (s2_ff & s3_ff) | (dout & (s2_ff | s3_ff));
		end
	end

endmodule // omc_sync3

/* File: rtl/omc_chan.sv */
/*
 * Operating mode manager for one machining channel: mode priority, mode
 * change table, channel state, stops, reset sequence and status bits.
 * Assumes the controller inputs are asynchronous levels; block_end and
 * prog_end come from the interpolator on clk_sys.
 */
`timescale 1ns/1ps
`include "omc_defines.svh"

module omc_chan (
	input  wire logic       clk_sys,
	input  wire logic       resetn,
	input  wire logic [2:0] mode_req,
	input  wire logic       mode_chg_disable,
	input  wire logic       func_ref_req,
	input  wire logic       func_teach_req,
	input  wire logic       stop_axes,
	input  wire logic       stop_axes_spindles,
	input  wire logic       stop_block_limit,
	input  wire logic       chan_reset_req,
	input  wire logic       nc_start,
	input  wire logic       block_search_req,
	input  wire logic       err_clear,
	input  wire logic       block_end,
	input  wire logic       prog_end,
	output logic      [2:0] mode_fb,
	output logic            func_ref_active,
	output logic            func_teach_active,
	output logic            ready_to_run,
	output logic            chan_reset_st,
	output logic            chan_active_st,
	output logic            chan_interrupted_st,
	output logic            mode_change_err,
	output logic            mode_change_pending,
	output logic            axes_halt,
	output logic            spindles_halt,
	output logic            prep_enable,
	output logic            aux_out_enable,
	output logic            block_ptr_clear,
	output logic            alarm_clear,
	output logic            search_active
);

	// ****************************************************************
	// Input synchronisation
	// ****************************************************************
	localparam int NIN = 13;

	logic [NIN-1:0]         sync_q;
	logic [2:0]             req_s;
	logic                   dis_s;
	logic                   ref_s;
	logic                   teach_s;
	logic                   stop_s;
	logic                   stop_sp_s;
	logic                   stop_bl_s;
	logic                   rst_s;
	logic                   start_s;
	logic                   search_s;
	logic                   errclr_s;

	omc_sync3 #(.W(NIN)) u_sync (
		.clk_sys (clk_sys),
		.resetn  (resetn),
		.din     ({mode_req, mode_chg_disable, func_ref_req, func_teach_req,
		           stop_axes, stop_axes_spindles, stop_block_limit,
		           chan_reset_req, nc_start, block_search_req, err_clear}),
		.dout    (sync_q)
	);

	assign {req_s, dis_s, ref_s, teach_s, stop_s, stop_sp_s, stop_bl_s,
	        rst_s, start_s, search_s, errclr_s} = sync_q;

	// ****************************************************************
	// State
	// ****************************************************************
	omc_pkg::omc_mode_t     mode_ff;
	omc_pkg::omc_mode_t     nxt_mode;
	omc_pkg::omc_mode_t     prev_ff;
	omc_pkg::omc_mode_t     pend_mode_ff;
	omc_pkg::omc_chan_t     chan_ff;
	omc_pkg::omc_chan_t     nxt_chan;
	logic                   pend_ff;
	logic [2:0]             last_req_ff;
	logic                   rst_d_ff;
	logic                   start_d_ff;
	logic                   bl_pend_ff;
	logic [`OMC_CNT_W-1:0]  rseq_cnt_ff;
	logic                   reject;
	logic                   accept;

	// Priority resolve: jog, then data input, else auto
	function automatic omc_pkg::omc_mode_t prio_mode(input logic [2:0] r);
		if (r[`OMC_REQ_JOG])
			return omc_pkg::OMC_JOG;
		else if (r[`OMC_REQ_MDATA])
			return omc_pkg::OMC_MDATA;
		else
			return omc_pkg::OMC_AUTO;
	endfunction

	// Allowed change out of the interrupted state
	function automatic logic int_allowed(input omc_pkg::omc_mode_t from,
	                                     input omc_pkg::omc_mode_t to,
	                                     input omc_pkg::omc_mode_t prev);
		if (from != omc_pkg::OMC_JOG)
			return to == omc_pkg::OMC_JOG;
		else
			return to == prev;
	endfunction

	// Three request bits with auto set alongside others resolve above it
	omc_pkg::omc_mode_t     tgt;
	logic                   req_any;
	logic                   req_new;
	logic                   in_jog;
	logic                   rst_rise;
	logic                   start_rise;
	logic                   stops_ok;

	assign tgt        = prio_mode(req_s);
	assign req_any    = |req_s;
	assign req_new    = req_s != last_req_ff;
	assign in_jog     = mode_ff == omc_pkg::OMC_JOG;
	assign rst_rise   = rst_s && !rst_d_ff;
	assign start_rise = start_s && !start_d_ff;
	assign stops_ok   = !stop_s && !stop_sp_s && !stop_bl_s;

	// ****************************************************************
	// Mode change request capture
	// ****************************************************************
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			last_req_ff  <= 3'h0;
			pend_ff      <= 1'b0;
			pend_mode_ff <= omc_pkg::OMC_AUTO;
		end else begin
			last_req_ff <= req_s;
			if (dis_s) begin
				pend_ff <= 1'b0;
			end else if (req_new) begin
				if (!req_any || tgt == mode_ff) begin
					pend_ff <= 1'b0;
				end else begin
					pend_ff      <= 1'b1;
					pend_mode_ff <= tgt;
				end
			end else if (accept || reject) begin
				pend_ff <= 1'b0;
			end
		end
	end

	// ****************************************************************
	// Mode change decision
	// ****************************************************************
	always_comb begin
		accept = 1'b0;
		reject = 1'b0;
		if (pend_ff && !dis_s && !req_new) begin
			unique case (chan_ff)
				omc_pkg::OMC_CH_RESET: accept = 1'b1;
				omc_pkg::OMC_CH_INT: begin
					accept = int_allowed(mode_ff, pend_mode_ff, prev_ff);
					reject = !accept;
				end
				omc_pkg::OMC_CH_ACT:  ;
				omc_pkg::OMC_CH_RSEQ: ;
			endcase
		end
	end

	always_comb begin
		nxt_mode = mode_ff;
		if (accept)
			nxt_mode = pend_mode_ff;
	end

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			mode_ff <= omc_pkg::omc_mode_t'(`OMC_MODE_RST);
			prev_ff <= omc_pkg::omc_mode_t'(`OMC_MODE_RST);
		end else begin
			mode_ff <= nxt_mode;
			if (accept && pend_mode_ff == omc_pkg::OMC_JOG)
				prev_ff <= mode_ff;
		end
	end

	// Error is sticky; a new rejection wins over the clear
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn)
			mode_change_err <= 1'b0;
		else if (reject)
			mode_change_err <= 1'b1;
		else if (errclr_s)
			mode_change_err <= 1'b0;
	end

	// ****************************************************************
	// Channel state
	// ****************************************************************
	always_comb begin
		nxt_chan = chan_ff;
		unique case (chan_ff)
			omc_pkg::OMC_CH_RESET, omc_pkg::OMC_CH_INT: begin
				if (!in_jog && start_rise && stops_ok &&
				    !(pend_ff && !dis_s))
					nxt_chan = omc_pkg::OMC_CH_ACT;
			end
			omc_pkg::OMC_CH_ACT: begin
				if (prog_end)
					nxt_chan = omc_pkg::OMC_CH_RESET;
				else if (stop_s || stop_sp_s ||
				         ((stop_bl_s || bl_pend_ff) && block_end))
					nxt_chan = omc_pkg::OMC_CH_INT;
			end
			omc_pkg::OMC_CH_RSEQ: begin
				if (rseq_cnt_ff == `OMC_CNT_W'(0))
					nxt_chan = omc_pkg::OMC_CH_RESET;
			end
		endcase
		if (rst_rise)
			nxt_chan = omc_pkg::OMC_CH_RSEQ;
	end

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			chan_ff    <= omc_pkg::omc_chan_t'(`OMC_CHAN_RST);
			rst_d_ff   <= 1'b0;
			start_d_ff <= 1'b0;
		end else begin
			chan_ff    <= nxt_chan;
			rst_d_ff   <= rst_s;
			start_d_ff <= start_s;
		end
	end

	// Block-limit stop remembered until the block ends
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn)
			bl_pend_ff <= 1'b0;
		else if (chan_ff != omc_pkg::OMC_CH_ACT || block_end)
			bl_pend_ff <= 1'b0;
		else if (stop_bl_s)
			bl_pend_ff <= 1'b1;
	end

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn)
			rseq_cnt_ff <= `OMC_CNT_W'(0);
		else if (rst_rise)
			rseq_cnt_ff <= `OMC_RSEQ_CYC;
		else if (rseq_cnt_ff != `OMC_CNT_W'(0))
			rseq_cnt_ff <= rseq_cnt_ff - `OMC_CNT_W'(1);
	end

	// ****************************************************************
	// Halt, preparation and auxiliary output control
	// ****************************************************************
	logic rseq_n;
	logic act_n;

	assign rseq_n = nxt_chan == omc_pkg::OMC_CH_RSEQ;
	assign act_n  = nxt_chan == omc_pkg::OMC_CH_ACT;

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			axes_halt      <= 1'b1;
			spindles_halt  <= 1'b1;
			prep_enable    <= 1'b0;
			aux_out_enable <= 1'b0;
		end else begin
			axes_halt      <= rseq_n || (!in_jog && (stop_s || stop_sp_s ||
			                  ((stop_bl_s || bl_pend_ff) &&
			                   block_end)));
			spindles_halt  <= rseq_n || (!in_jog && stop_sp_s);
			prep_enable    <= act_n;
			aux_out_enable <= act_n && !rst_rise;
		end
	end

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			block_ptr_clear <= 1'b0;
			alarm_clear     <= 1'b0;
		end else begin
			block_ptr_clear <= rst_rise;
			alarm_clear     <= rst_rise;
		end
	end

	// ****************************************************************
	// Block search
	// ****************************************************************
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn)
			search_active <= 1'b0;
		else if (rst_rise || accept || nxt_chan == omc_pkg::OMC_CH_ACT)
			search_active <= 1'b0;
		else if (search_s && mode_ff == omc_pkg::OMC_AUTO &&
		         (chan_ff == omc_pkg::OMC_CH_RESET ||
		          chan_ff == omc_pkg::OMC_CH_INT))
			search_active <= 1'b1;
	end

	// ****************************************************************
	// Status outputs
	// ****************************************************************
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			mode_fb             <= 3'h0;
			func_ref_active     <= 1'b0;
			func_teach_active   <= 1'b0;
			ready_to_run        <= 1'b0;
			chan_reset_st       <= 1'b0;
			chan_active_st      <= 1'b0;
			chan_interrupted_st <= 1'b0;
			mode_change_pending <= 1'b0;
		end else begin
			mode_fb <= 3'h0;
			mode_fb[nxt_mode] <= 1'b1;
			func_ref_active <= ref_s &&
			                   nxt_mode == omc_pkg::OMC_JOG;
			func_teach_active <= teach_s &&
			                     nxt_mode == omc_pkg::OMC_MDATA;
			ready_to_run <= !rseq_n;
			chan_reset_st <= nxt_chan == omc_pkg::OMC_CH_RESET;
			chan_active_st <= act_n;
			chan_interrupted_st <= nxt_chan == omc_pkg::OMC_CH_INT;
			mode_change_pending <= pend_ff && !accept && !reject;
		end
	end

endmodule // omc_chan

/* File: sim/omc_chan_assertions.sv */
/*
 * Checker of the mode and channel block, bound into omc_chan.
 * Assumes one clk_sys domain and the active-low resetn of the block.
 */
`timescale 1ns/1ps

module omc_chan_chk (
	input logic       clk_sys,
	input logic       resetn,
	input logic       mode_chg_disable,
	input logic [2:0] mode_fb,
	input logic       func_ref_active,
	input logic       func_teach_active,
	input logic       ready_to_run,
	input logic       chan_reset_st,
	input logic       chan_active_st,
	input logic       chan_interrupted_st,
	input logic       mode_change_err,
	input logic       axes_halt,
	input logic       spindles_halt,
	input logic       prep_enable,
	input logic       block_ptr_clear,
	input logic       alarm_clear
);
	logic [2:0] st;

	assign st = {chan_reset_st, chan_active_st, chan_interrupted_st};

	default clocking @(posedge clk_sys); endclocking
	default disable iff (!resetn);

	// ****************
	// Properties
	// ****************
	chk_mode_onehot: assert property (
		$past(resetn) |-> $onehot(mode_fb))
		else $error("mode feedback not one-hot");
	chk_state_onehot: assert property (
		$past(resetn) && ready_to_run |-> $onehot(st))
		else $error("channel state not one-hot");
	chk_ref_jog: assert property (
		func_ref_active |-> mode_fb == 3'h4)
		else $error("reference function outside jog");
	chk_teach_mdata: assert property (
		func_teach_active |-> mode_fb == 3'h2)
		else $error("teach function outside data input");
	chk_hold_active: assert property (
		!$stable(mode_fb) |-> !$past(chan_active_st))
		else $error("mode changed while active");
	chk_disable_hold: assert property (
		mode_chg_disable [*8] |=> $stable(mode_fb))
		else $error("mode changed while disabled");
	chk_reset_entry: assert property (
		$rose(block_ptr_clear) |-> alarm_clear && axes_halt &&
		spindles_halt && !prep_enable ##1 !block_ptr_clear)
		else $error("reset entry wrong");
	chk_reset_done: assert property (
		$rose(block_ptr_clear) |-> !ready_to_run ##5
		chan_reset_st && ready_to_run)
		else $error("reset completion wrong");
	chk_int_halt: assert property (
		$rose(chan_interrupted_st) |-> axes_halt)
		else $error("interrupt without axis halt");
	chk_err_keep: assert property (
		$fell(mode_change_err) && ready_to_run && $past(ready_to_run)
		|-> $stable(st))
		else $error("error clear changed state");
	chk_start_mode: assert property (
		$rose(chan_active_st) |-> prep_enable && !mode_fb[2])
		else $error("start in wrong mode");

	cover property ($rose(mode_change_err));
	cover property ($rose(chan_interrupted_st));
	cover property ($rose(block_ptr_clear));
endmodule // omc_chan_chk

bind omc_chan omc_chan_chk i_chk (.*);

/* File: sim/omc_plc.sv */
/*
 * Behavioural controller driving the interface bits of the block.
 * Assumes the bench sets its levels at falling clock edges.
 */
`timescale 1ns/1ps

module omc_plc (
	input  logic       clk_sys,
	input  logic [2:0] mode_fb,
	output logic [2:0] mode_req,
	output logic       mode_chg_disable,
	output logic       func_ref_req,
	output logic       func_teach_req,
	output logic       stop_axes,
	output logic       stop_axes_spindles,
	output logic       stop_block_limit,
	output logic       chan_reset_req,
	output logic       nc_start,
	output logic       block_search_req,
	output logic       err_clear,
	output logic       block_end,
	output logic       prog_end
);
	logic ref_want;
	logic teach_want;

	// Functions requested only in their own mode
	assign func_ref_req   = ref_want & mode_fb[2];
	assign func_teach_req = teach_want & mode_fb[1];

	initial begin
		{mode_req, mode_chg_disable, ref_want, teach_want} = '0;
		{stop_axes, stop_axes_spindles, stop_block_limit} = '0;
		{chan_reset_req, nc_start, block_search_req} = '0;
		{err_clear, block_end, prog_end} = '0;
	end

	// ****************
	// Edge requests
	// ****************
	// Held six cycles each way so the synchroniser sees them
	task automatic edge_req(input bit rst);
		chan_reset_req = rst;
		nc_start = !rst;
		repeat (6) @(negedge clk_sys);
		chan_reset_req = 1'b0;
		nc_start = 1'b0;
		repeat (6) @(negedge clk_sys);
	endtask

	// One-cycle block end or program end pulse
	task automatic pulse(input bit prg);
		block_end = !prg;
		prog_end = prg;
		@(negedge clk_sys);
		block_end = 1'b0;
		prog_end = 1'b0;
	endtask
endmodule // omc_plc

/* File: sim/operating_mode_channel_control_test.sv */
/*
 * Self-checking bench of omc_chan with a controller model.
 * Assumes omc_chan, omc_plc and the bound checker are compiled first.
 */
`timescale 1ns/1ps

module operating_mode_channel_control_test;
	logic       clk_sys;
	logic       resetn;
	logic       seen_clr = 1'b0;
	int         num_errors = 0;
	int         n_compared = 0;
	int         cyc = 0;
	logic [2:0] mode_req, mode_fb;
	logic       mode_chg_disable, func_ref_req, func_teach_req;
	logic       stop_axes, stop_axes_spindles, stop_block_limit;
	logic       chan_reset_req, nc_start, block_search_req, err_clear;
	logic       block_end, prog_end, func_ref_active, func_teach_active;
	logic       ready_to_run, chan_reset_st, chan_active_st;
	logic       chan_interrupted_st, mode_change_err, mode_change_pending;
	logic       axes_halt, spindles_halt, prep_enable, aux_out_enable;
	logic       block_ptr_clear, alarm_clear, search_active;

	omc_chan i_dut (.*);
	omc_plc  i_plc (.*);

	always #10 clk_sys = ~clk_sys;

	always @(posedge clk_sys) begin
		cyc <= cyc + 1;
		if (block_ptr_clear & alarm_clear) begin
			seen_clr <= 1'b1;
		end
		if (cyc == 3000) begin
			num_errors++;
			print_verdict();
		end
	end

	// ****************
	// Helpers
	// ****************
	task automatic step(input int n);
		repeat (n) @(negedge clk_sys);
	endtask

	task automatic req(input logic [2:0] m);
		i_plc.mode_req = m;
		step(8);
	endtask

	task automatic cmp(input logic [2:0] got, input logic [2:0] exp);
		n_compared++;
		if (got !== exp) begin
			num_errors++;
			$display("mismatch at %0t: got %b want %b", $time, got, exp);
		end
	endtask

	task automatic print_verdict();
		$display("errors %0d compared %0d", num_errors, n_compared);
		if (num_errors == 0 && n_compared > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask

	// ****************
	// Scenarios
	// ****************
	task automatic t_boot();
		cmp(mode_fb, 3'h1);
		cmp({chan_reset_st, ready_to_run, axes_halt}, 3'h6);
	endtask

	task automatic t_prio();
		req(3'h7);
		cmp(mode_fb, 3'h4);
		req(3'h3);
		cmp(mode_fb, 3'h2);
		req(3'h1);
		cmp(mode_fb, 3'h1);
		req(3'h0);
		cmp({mode_change_err, mode_fb[0]}, 3'h1);
	endtask

	task automatic t_disable();
		i_plc.mode_chg_disable = 1'b1;
		step(8);
		req(3'h4);
		cmp(mode_fb, 3'h1);
		req(3'h0);
		i_plc.mode_chg_disable = 1'b0;
		step(8);
	endtask

	task automatic t_func();
		req(3'h4);
		i_plc.ref_want = 1'b1;
		step(8);
		cmp(func_ref_active, 1'b1);
		i_plc.edge_req(1'b0);
		cmp(chan_active_st, 1'b0);
		i_plc.ref_want = 1'b0;
		req(3'h2);
		i_plc.teach_want = 1'b1;
		i_plc.block_search_req = 1'b1;
		step(8);
		cmp({func_ref_active, func_teach_active}, 3'h1);
		cmp(search_active, 1'b0);
		i_plc.teach_want = 1'b0;
		i_plc.block_search_req = 1'b0;
		req(3'h1);
	endtask

	task automatic t_run();
		i_plc.block_search_req = 1'b1;
		step(8);
		cmp(search_active, 1'b1);
		i_plc.block_search_req = 1'b0;
		i_plc.edge_req(1'b0);
		cmp({chan_active_st, prep_enable, aux_out_enable}, 3'h7);
		cmp(search_active, 1'b0);
		req(3'h4);
		cmp({mode_change_pending, mode_fb[0]}, 3'h3);
		i_plc.stop_axes = 1'b1;
		step(8);
		cmp({chan_interrupted_st, spindles_halt}, 3'h2);
		cmp(mode_fb, 3'h4);
		i_plc.stop_axes = 1'b0;
		req(3'h2);
		cmp({mode_change_err, mode_fb[2]}, 3'h3);
		i_plc.err_clear = 1'b1;
		step(8);
		i_plc.err_clear = 1'b0;
		cmp({mode_change_err, chan_interrupted_st}, 3'h1);
		req(3'h1);
		cmp(mode_fb, 3'h1);
	endtask

	task automatic t_stops();
		i_plc.edge_req(1'b0);
		i_plc.stop_axes_spindles = 1'b1;
		step(8);
		cmp({chan_interrupted_st, axes_halt, spindles_halt}, 3'h7);
		i_plc.stop_axes_spindles = 1'b0;
		i_plc.edge_req(1'b0);
		i_plc.stop_block_limit = 1'b1;
		step(8);
		cmp(chan_active_st, 1'b1);
		i_plc.pulse(1'b0);
		step(2);
		cmp(chan_interrupted_st, 1'b1);
		i_plc.stop_block_limit = 1'b0;
	endtask

	task automatic t_reset();
		i_plc.edge_req(1'b0);
		i_plc.pulse(1'b1);
		cmp({chan_reset_st, chan_active_st, prep_enable}, 3'h4);
		i_plc.edge_req(1'b0);
		i_plc.edge_req(1'b1);
		cmp({chan_reset_st, ready_to_run, prep_enable}, 3'h6);
		cmp({aux_out_enable, axes_halt, spindles_halt}, 3'h0);
		cmp(seen_clr, 1'b1);
	endtask

	initial begin
		clk_sys = 1'b0;
		resetn = 1'b0;
		step(20);
		resetn = 1'b1;
		step(2);
		t_boot();
		t_prio();
		t_disable();
		t_func();
		t_run();
		t_stops();
		t_reset();
		print_verdict();
	end
endmodule // operating_mode_channel_control_test
